// ==== shared/shadow_uart_pkg.sv ====
// Shared constants for the UART shadow data port window
package shadow_uart_pkg;
	localparam int ADDR_W  = 32;
	localparam int DATA_W  = 32;
	localparam int BYTE_W  = 8;
	localparam int STRB_W  = 4;
	localparam int DEPTH   = 16;
	localparam int PTR_W   = 4;
	localparam int CNT_W   = 5;
	localparam int IRQ_W   = 3;
	// ****************************************************************
	// Address map
	// ****************************************************************
	localparam logic [31:0] SHADOW_BASE = 32'h50001130;
	localparam logic [31:0] SHADOW_LAST = 32'h5000116c;
	localparam logic [31:0] ALIAS_2     = 32'h50001138;
	localparam logic [31:0] ALIAS_3     = 32'h5000113c;
	localparam logic [31:0] CTRL_ADDR   = 32'h50001180;
	localparam logic [31:0] LSTAT_ADDR  = 32'h50001184;
	localparam logic [31:0] ISTAT_ADDR  = 32'h50001188;
	localparam logic [31:0] IMASK_ADDR  = 32'h5000118c;
	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CTRL_FIFO_EN = 0;
	localparam int CTRL_IR_MODE = 1;
	localparam int LS_DR        = 0;
	localparam int LS_OVR       = 1;
	localparam int LS_TX_HOLDING_EMPTY_FLAG      = 5;
	localparam int IS_RX        = 0;
	localparam int IS_OVR       = 1;
	localparam int IS_DROP      = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic is_shadow(input logic [31:0] a);
		return (a >= SHADOW_BASE) && (a <= SHADOW_LAST) && (a[1:0] == 2'h0);
	endfunction : is_shadow

	function automatic logic is_mapped(input logic [31:0] a);
		return is_shadow(a) || (a == CTRL_ADDR) || (a == LSTAT_ADDR) ||
			(a == ISTAT_ADDR) || (a == IMASK_ADDR);
	endfunction : is_mapped
endpackage : shadow_uart_pkg

// ==== shared/reg_access_if.sv ====
// Register access strobes between the bus front end and the register file
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
	import shadow_uart_pkg::*;
	logic              wr;
	logic [ADDR_W-1:0] waddr;
	logic [DATA_W-1:0] wdata;
	logic [STRB_W-1:0] wstrb;
	logic              werr;
	logic              rd;
	logic [ADDR_W-1:0] raddr;
	logic [DATA_W-1:0] rdata;
	logic              rerr;
	modport front (output wr, waddr, wdata, wstrb, rd, raddr,
		input werr, rdata, rerr);
	modport regs (input wr, waddr, wdata, wstrb, rd, raddr,
		output werr, rdata, rerr);
endinterface : reg_access_if
`default_nettype wire

// ==== verilog/byte_fifo.sv ====
// Byte FIFO used for both the receive and the transmit path
`timescale 1ns/100ps
`default_nettype none
module byte_fifo
(
	input  wire logic                               mclk,
	input  wire logic                               rst,
	input  wire logic                               flush,
	input  wire logic                               push,
	input  wire logic [shadow_uart_pkg::BYTE_W-1:0] din,
	input  wire logic                               pop,
	output logic      [shadow_uart_pkg::BYTE_W-1:0] dout,
	output logic                                    empty,
	output logic                                    full
);
	import shadow_uart_pkg::*;

	logic [BYTE_W-1:0] mem [DEPTH];
	logic [PTR_W-1:0]  wptr_ff;
	logic [PTR_W-1:0]  rptr_ff;
	logic [CNT_W-1:0]  cnt_ff;
	logic              do_push;
	logic              do_pop;

	assign empty   = (cnt_ff == '0);
	assign full    = (cnt_ff == CNT_W'(DEPTH));
	assign do_pop  = pop && !empty;
	// A pop in the same cycle frees a slot, so a full FIFO may still take
	assign do_push = push && (!full || do_pop);
	assign dout    = mem[rptr_ff];

	always_ff @(posedge mclk)
	begin
		if (do_push)
			mem[wptr_ff] <= din;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || flush)
		begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff  <= '0;
		end
		else
		begin
			wptr_ff <= wptr_ff + PTR_W'(do_push);
			rptr_ff <= rptr_ff + PTR_W'(do_pop);
			cnt_ff  <= cnt_ff + CNT_W'(do_push) - CNT_W'(do_pop);
		end
	end
endmodule : byte_fifo
`default_nettype wire

// ==== verilog/axil_front.sv ====
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/100ps
`default_nettype none
module axil_front
(
	input  wire logic                               mclk,
	input  wire logic                               rst,
	input  wire logic [shadow_uart_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                               awvalid,
	output logic                                    awready,
	input  wire logic [shadow_uart_pkg::DATA_W-1:0] wdata,
	input  wire logic [shadow_uart_pkg::STRB_W-1:0] wstrb,
	input  wire logic                               wvalid,
	output logic                                    wready,
	output logic      [1:0]                         bresp,
	output logic                                    bvalid,
	input  wire logic                               bready,
	input  wire logic [shadow_uart_pkg::ADDR_W-1:0] araddr,
	input  wire logic                               arvalid,
	output logic                                    arready,
	output logic      [shadow_uart_pkg::DATA_W-1:0] rdata,
	output logic      [1:0]                         rresp,
	output logic                                    rvalid,
	input  wire logic                               rready,
	reg_access_if.front                             bus
);
	import shadow_uart_pkg::*;

	logic aw_have_ff;
	logic w_have_ff;
	logic rd_pend_ff;
	logic [ADDR_W-1:0] waddr_ff;
	logic [ADDR_W-1:0] raddr_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [STRB_W-1:0] wstrb_ff;

	// ****************************************************************
	// Write channel: address and data in either order
	// ****************************************************************
	assign awready   = !aw_have_ff && !bvalid;
	assign wready    = !w_have_ff && !bvalid;
	assign bus.wr    = aw_have_ff && w_have_ff && !bvalid;
	assign bus.waddr = waddr_ff;
	assign bus.wdata = wdata_ff;
	assign bus.wstrb = wstrb_ff;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			waddr_ff   <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
			bvalid     <= 1'b0;
			bresp      <= RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_have_ff <= 1'b1;
				waddr_ff   <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_have_ff <= 1'b1;
				wdata_ff  <= wdata;
				wstrb_ff  <= wstrb;
			end
			if (bus.wr)
			begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bvalid     <= 1'b1;
				bresp      <= bus.werr ? RESP_SLVERR : RESP_OKAY;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// Read channel: one outstanding read
	// ****************************************************************
	assign arready   = !rd_pend_ff && !rvalid;
	assign bus.rd    = rd_pend_ff;
	assign bus.raddr = raddr_ff;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rd_pend_ff <= 1'b0;
			raddr_ff   <= '0;
			rvalid     <= 1'b0;
			rdata      <= '0;
			rresp      <= RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rd_pend_ff <= 1'b1;
			raddr_ff   <= araddr;
		end
		else if (rd_pend_ff)
		begin
			rd_pend_ff <= 1'b0;
			rvalid     <= 1'b1;
			rdata      <= bus.rdata;
			rresp      <= bus.rerr ? RESP_SLVERR : RESP_OKAY;
		end
		else if (rready)
			rvalid <= 1'b0;
	end
endmodule : axil_front
`default_nettype wire

// ==== verilog/uart_shadow_buffer_access.sv ====
// UART shadow data port window with its control and status registers
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE_01: Sixteen word aliases all reach the data port
// RULE_02: Read returns serial or infrared received byte
// RULE_03: Software trusts data only while ready flag set
// RULE_04: FIFOs off: new byte overwrites, flags overrun
// RULE_05: FIFOs on: read returns and pops oldest
// RULE_06: Full receive FIFO keeps contents, drops, overruns
// RULE_07: Write queues byte for serial or infrared
// RULE_08: Software writes only while holding empty set
// RULE_09: FIFOs off: write clears empty, rewrites replace
// RULE_10: FIFOs on: sixteen writes accepted before full
// RULE_11: Write to full transmit FIFO is dropped
// RULE_12: Data bits 15:8 read zero, writes ignored
module uart_shadow_buffer_access
(
	input  wire logic                              mclk,
	input  wire logic                              rst,
	input  wire logic [shadow_uart_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                              awvalid,
	output logic                                   awready,
	input  wire logic [shadow_uart_pkg::DATA_W-1:0] wdata,
	input  wire logic [shadow_uart_pkg::STRB_W-1:0] wstrb,
	input  wire logic                              wvalid,
	output logic                                   wready,
	output logic      [1:0]                        bresp,
	output logic                                   bvalid,
	input  wire logic                              bready,
	input  wire logic [shadow_uart_pkg::ADDR_W-1:0] araddr,
	input  wire logic                              arvalid,
	output logic                                   arready,
	output logic      [shadow_uart_pkg::DATA_W-1:0] rdata,
	output logic      [1:0]                        rresp,
	output logic                                   rvalid,
	input  wire logic                              rready,
	input  wire logic [shadow_uart_pkg::BYTE_W-1:0] rx_ser_byte,
	input  wire logic                              rx_ser_valid,
	input  wire logic [shadow_uart_pkg::BYTE_W-1:0] rx_ir_byte,
	input  wire logic                              rx_ir_valid,
	output logic      [shadow_uart_pkg::BYTE_W-1:0] tx_byte,
	output logic                                   tx_ser_valid,
	output logic                                   tx_ir_valid,
	input  wire logic                              tx_ready,
	output logic                                   irq
);
	import shadow_uart_pkg::*;

	reg_access_if bus ();

	logic [1:0]        ctrl_ff;
	logic [BYTE_W-1:0] receive_buffer_ff;
	logic [BYTE_W-1:0] transmit_holding_ff;
	logic              rx_data_ready_flag_ff;
	logic              tx_holding_empty_flag_ff;
	logic              ovr_ff;
	logic [IRQ_W-1:0]  ist_ff;
	logic [IRQ_W-1:0]  imask_ff;
	logic [IRQ_W-1:0]  evt;
	logic              fifo_en;
	logic              ir_mode;
	logic              flush;
	logic              rx_valid;
	logic [BYTE_W-1:0] rx_byte;
	logic              rd_shadow;
	logic              wr_shadow;
	logic              rx_pop;
	logic              rx_empty;
	logic              rx_full;
	logic [BYTE_W-1:0] rx_head;
	logic              tx_push;
	logic              tx_pop;
	logic              tx_empty;
	logic              tx_full;
	logic [BYTE_W-1:0] tx_head;
	logic              tx_taken;
	logic              tx_any;
	logic              ovr_evt;
	logic              drop_evt;
	logic              data_ready;
	logic              tx_holding_empty_flag;

	axil_front u_front (
		.mclk    (mclk),
		.rst     (rst),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.bus     (bus.front)
	);

	// ****************************************************************
	// Mode selection and access decode
	// ****************************************************************
	assign fifo_en  = ctrl_ff[CTRL_FIFO_EN];
	assign ir_mode  = ctrl_ff[CTRL_IR_MODE];
	// Changing the FIFO mode empties both FIFOs so no stale byte leaks
	assign flush    = bus.wr && (bus.waddr == CTRL_ADDR) && bus.wstrb[0] &&
		(bus.wdata[CTRL_FIFO_EN] != fifo_en);
	assign rx_valid = ir_mode ? rx_ir_valid : rx_ser_valid; // RULE_02
	assign rx_byte  = ir_mode ? rx_ir_byte : rx_ser_byte; // RULE_02
	assign rd_shadow = bus.rd && is_shadow(bus.raddr); // RULE_01
	// Only the low lane carries data; upper lanes are dropped
	assign wr_shadow = bus.wr && is_shadow(bus.waddr) && bus.wstrb[0]; // RULE_12
	assign bus.werr  = !is_mapped(bus.waddr);
	assign bus.rerr  = !is_mapped(bus.raddr);

	// ****************************************************************
	// Receive path
	// ****************************************************************
	assign rx_pop  = fifo_en && rd_shadow; // RULE_05
	assign ovr_evt = rx_valid && (fifo_en ? (rx_full && !rx_pop) :
		(rx_data_ready_flag_ff && !rd_shadow)); // RULE_04 RULE_06

	byte_fifo u_rx_fifo (
		.mclk  (mclk),
		.rst   (rst),
		.flush (flush),
		.push  (fifo_en && rx_valid),
		.din   (rx_byte),
		.pop   (rx_pop),
		.dout  (rx_head),
		.empty (rx_empty),
		.full  (rx_full)
	);

	always_ff @(posedge mclk)
	begin
		if (rst)
			receive_buffer_ff <= '0;
		else if (!fifo_en && rx_valid)
			receive_buffer_ff <= rx_byte; // RULE_04
	end

	// A byte landing in the same cycle as the read keeps the flag set
	always_ff @(posedge mclk)
	begin
		if (rst || flush)
			rx_data_ready_flag_ff <= 1'b0;
		else if (!fifo_en && rx_valid)
			rx_data_ready_flag_ff <= 1'b1;
		else if (rd_shadow)
			rx_data_ready_flag_ff <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			ovr_ff <= 1'b0;
		else if (ovr_evt)
			ovr_ff <= 1'b1; // RULE_04 RULE_06
		else if (bus.rd && (bus.raddr == LSTAT_ADDR))
			ovr_ff <= 1'b0;
	end

	// ****************************************************************
	// Transmit path
	// ****************************************************************
	assign tx_any   = fifo_en ? !tx_empty : !tx_holding_empty_flag_ff;
	assign tx_ser_valid = tx_any && !ir_mode; // RULE_07
	assign tx_ir_valid  = tx_any && ir_mode; // RULE_07
	assign tx_byte  = fifo_en ? tx_head : transmit_holding_ff;
	assign tx_taken = tx_any && tx_ready;
	assign tx_push  = fifo_en && wr_shadow; // RULE_10
	assign tx_pop   = fifo_en && tx_taken;
	assign drop_evt = tx_push && tx_full && !tx_pop; // RULE_11

	byte_fifo u_tx_fifo (
		.mclk  (mclk),
		.rst   (rst),
		.flush (flush),
		.push  (tx_push),
		.din   (bus.wdata[BYTE_W-1:0]),
		.pop   (tx_pop),
		.dout  (tx_head),
		.empty (tx_empty),
		.full  (tx_full)
	);

	always_ff @(posedge mclk)
	begin
		if (rst)
			transmit_holding_ff <= '0;
		else if (!fifo_en && wr_shadow)
			transmit_holding_ff <= bus.wdata[BYTE_W-1:0]; // RULE_09
	end

	// A write racing the transmitter's take leaves the new byte pending
	always_ff @(posedge mclk)
	begin
		if (rst || flush)
			tx_holding_empty_flag_ff <= 1'b1;
		else if (!fifo_en && wr_shadow)
			tx_holding_empty_flag_ff <= 1'b0; // RULE_09
		else if (!fifo_en && tx_taken)
			tx_holding_empty_flag_ff <= 1'b1;
	end

	// ****************************************************************
	// Control, interrupt and read-back registers
	// ****************************************************************
	assign data_ready = fifo_en ? !rx_empty : rx_data_ready_flag_ff;
	assign tx_holding_empty_flag       = fifo_en ? tx_empty : tx_holding_empty_flag_ff;
	assign evt        = {drop_evt, ovr_evt, rx_valid};
	assign irq        = |(ist_ff & imask_ff);

	always_ff @(posedge mclk)
	begin
		if (rst)
			ctrl_ff <= CTRL_RESET;
		else if (bus.wr && (bus.waddr == CTRL_ADDR) && bus.wstrb[0])
			ctrl_ff <= bus.wdata[1:0];
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			imask_ff <= '0;
		else if (bus.wr && (bus.waddr == IMASK_ADDR) && bus.wstrb[0])
			imask_ff <= bus.wdata[IRQ_W-1:0];
	end

	// Write one to clear; a new event in the same cycle still sets
	always_ff @(posedge mclk)
	begin
		if (rst)
			ist_ff <= '0;
		else if (bus.wr && (bus.waddr == ISTAT_ADDR) && bus.wstrb[0])
			ist_ff <= (ist_ff & ~bus.wdata[IRQ_W-1:0]) | evt;
		else
			ist_ff <= ist_ff | evt;
	end

	always_comb
	begin
		bus.rdata = '0;
		if (is_shadow(bus.raddr))
			bus.rdata[BYTE_W-1:0] = fifo_en ? rx_head :
				receive_buffer_ff; // RULE_05 RULE_12
		else if (bus.raddr == CTRL_ADDR)
			bus.rdata[1:0] = ctrl_ff;
		else if (bus.raddr == LSTAT_ADDR)
		begin
			bus.rdata[LS_DR]   = data_ready; // RULE_03
			bus.rdata[LS_OVR]  = ovr_ff;
			bus.rdata[LS_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag; // RULE_08
		end
		else if (bus.raddr == ISTAT_ADDR)
			bus.rdata[IRQ_W-1:0] = ist_ff;
		else if (bus.raddr == IMASK_ADDR)
			bus.rdata[IRQ_W-1:0] = imask_ff;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_alias;
		arvalid && arready && is_shadow(araddr) && !fifo_en && !rx_valid
		|=> ##1 rvalid && (rresp == RESP_OKAY) &&
			(rdata[BYTE_W-1:0] == $past(receive_buffer_ff));
	endproperty
	a_alias: assert property (p_alias) else $error("alias read wrong"); // RULE_01

	property p_rx_sel;
		rx_ir_valid && ir_mode && !fifo_en
		|=> receive_buffer_ff == $past(rx_ir_byte);
	endproperty
	a_rx_sel: assert property (p_rx_sel) else $error("ir byte lost"); // RULE_02

	property p_overwrite;
		!fifo_en && rx_valid && rx_data_ready_flag_ff && !rd_shadow && !flush
		|=> ovr_ff && ist_ff[IS_OVR] && rx_data_ready_flag_ff;
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("no overrun"); // RULE_04

	property p_rx_head;
		rd_shadow && fifo_en && !rx_empty
		|=> rvalid && (rdata[BYTE_W-1:0] == $past(rx_head));
	endproperty
	a_rx_head: assert property (p_rx_head) else $error("bad fifo head"); // RULE_05

	property p_rx_full;
		fifo_en && rx_full && rx_valid && !rd_shadow && !flush
		|=> rx_full && ovr_ff && $stable(rx_head);
	endproperty
	a_rx_full: assert property (p_rx_full) else $error("full fifo changed"); // RULE_06

	property p_tx_ir;
		wr_shadow && !fifo_en && ir_mode && !flush
		|=> tx_ir_valid && !tx_ser_valid &&
			(tx_byte == $past(bus.wdata[BYTE_W-1:0]));
	endproperty
	a_tx_ir: assert property (p_tx_ir) else $error("ir tx not queued"); // RULE_07

	property p_tx_holding_empty_flag;
		wr_shadow && !fifo_en && !flush |=> !tx_holding_empty_flag ##0 tx_any;
	endproperty
	a_tx_holding_empty_flag: assert property (p_tx_holding_empty_flag) else $error("empty flag stuck"); // RULE_09

	property p_tx_accept;
		fifo_en && tx_empty && wr_shadow && !flush |=> !tx_full && !tx_empty;
	endproperty
	a_tx_accept: assert property (p_tx_accept) else $error("push lost"); // RULE_10

	property p_tx_drop;
		drop_evt && !flush |=> tx_full && $stable(tx_head) && ist_ff[IS_DROP];
	endproperty
	a_tx_drop: assert property (p_tx_drop) else $error("full fifo took"); // RULE_11

	property p_hi_zero;
		$rose(rvalid) && $past(rd_shadow)
		|-> (rresp == RESP_OKAY) && (rdata[DATA_W-1:BYTE_W] == '0);
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper bits set"); // RULE_12
endmodule : uart_shadow_buffer_access
`default_nettype wire

// ==== bench/uart_far_end.sv ====
// Far end model: framer byte source and transmitter sink
`timescale 1ns/100ps
`default_nettype none
module uart_far_end
(
	input  wire logic                               mclk,
	input  wire logic                               stall,
	input  wire logic [shadow_uart_pkg::BYTE_W-1:0] tx_byte,
	input  wire logic                               tx_ser_valid,
	input  wire logic                               tx_ir_valid,
	output logic                                    tx_ready,
	output logic      [shadow_uart_pkg::BYTE_W-1:0] rx_ser_byte,
	output logic                                    rx_ser_valid,
	output logic      [shadow_uart_pkg::BYTE_W-1:0] rx_ir_byte,
	output logic                                    rx_ir_valid
);
	import shadow_uart_pkg::*;

	// Taken bytes, infrared flag on top
	logic [BYTE_W:0] got[$];
	initial
	begin
		tx_ready = 1'b0;
		rx_ser_byte = 8'h00;
		rx_ser_valid = 1'b0;
		rx_ir_byte = 8'h00;
		rx_ir_valid = 1'b0;
	end
	// Ready lags stall by a cycle, like a shifter that is still busy
	always @(posedge mclk)
	begin
		tx_ready <= !stall;
		if (tx_ready && (tx_ser_valid || tx_ir_valid))
			got.push_back({tx_ir_valid, tx_byte});
	end
	// Data lines invert after the strobe so a stale byte never looks valid
	task automatic send(input logic ir, input logic [BYTE_W-1:0] b);
		@(posedge mclk);
		rx_ser_byte <= b;
		rx_ir_byte <= b;
		rx_ser_valid <= !ir;
		rx_ir_valid <= ir;
		@(posedge mclk);
		rx_ser_valid <= 1'b0;
		rx_ir_valid <= 1'b0;
		rx_ser_byte <= ~b;
		rx_ir_byte <= ~b;
	endtask : send
endmodule : uart_far_end
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the UART shadow data port window
`timescale 1ns/100ps
`default_nettype none
module tb;
	import shadow_uart_pkg::*;
	logic              mclk, rst, stall;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, irq, tx_ready;
	logic              rx_ser_valid, rx_ir_valid, tx_ser_valid, tx_ir_valid;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [STRB_W-1:0] wstrb;
	logic [1:0]        bresp, rresp;
	logic [BYTE_W-1:0] rx_ser_byte, rx_ir_byte, tx_byte;
	int                n_fail, num_checks;
	uart_shadow_buffer_access i_dut (.mclk(mclk), .rst(rst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.rx_ser_byte(rx_ser_byte), .rx_ser_valid(rx_ser_valid),
		.rx_ir_byte(rx_ir_byte), .rx_ir_valid(rx_ir_valid),
		.tx_byte(tx_byte), .tx_ser_valid(tx_ser_valid),
		.tx_ir_valid(tx_ir_valid), .tx_ready(tx_ready), .irq(irq));
	uart_far_end i_far (.mclk(mclk), .stall(stall), .tx_byte(tx_byte),
		.tx_ser_valid(tx_ser_valid), .tx_ir_valid(tx_ir_valid),
		.tx_ready(tx_ready), .rx_ser_byte(rx_ser_byte),
		.rx_ser_valid(rx_ser_valid), .rx_ir_byte(rx_ir_byte),
		.rx_ir_valid(rx_ir_valid));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ****************************************************************
	// Compare and bus tasks
	// ****************************************************************
	task automatic report_and_stop;
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic chk_word(input logic [DATA_W-1:0] g, e);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_word
	task automatic chk_bit(input logic g, e);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %0t flag %b exp %b", $time, g, e);
		end
	endtask : chk_bit
	task automatic axi_wr(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [1:0] r);
		logic aw, w;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w)
		begin
			@(posedge mclk);
			if (aw && awready === 1'b1)
			begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1)
			begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge mclk);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d, output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_word({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : wr
	task automatic rd_chk(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] d;
		logic [1:0]        r;
		axi_rd(a, d, r);
		chk_word(d, e);
		chk_word({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : rd_chk
	// Poll until the transmit side runs dry, then check what arrived
	task automatic drain_chk(input int n, input logic ir, input logic [7:0] b);
		logic [DATA_W-1:0] d;
		logic [1:0]        r;
		@(posedge mclk);
		stall <= 1'b0;
		do axi_rd(LSTAT_ADDR, d, r); while (d[LS_TX_HOLDING_EMPTY_FLAG] !== 1'b1);
		chk_word(32'(i_far.got.size()), 32'(n));
		for (int i = 0; i < n && i < i_far.got.size(); i++)
			chk_word(32'(i_far.got[i]), {23'h0, ir, b + 8'(i)});
		i_far.got.delete();
	endtask : drain_chk
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		logic [DATA_W-1:0] d;
		logic [1:0]        r;
		{rst, stall, awvalid, wvalid, bready, arvalid, rready} = 7'h41;
		{awaddr, araddr, wdata, wstrb} = '0;
		n_fail = 0;
		num_checks = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd_chk(CTRL_ADDR, 32'h0);
		rd_chk(LSTAT_ADDR, 32'h20);
		i_far.send(1'b0, 8'ha5);
		rd_chk(LSTAT_ADDR, 32'h21);
		rd_chk(ALIAS_2, 32'ha5);
		rd_chk(LSTAT_ADDR, 32'h20);
		i_far.send(1'b0, 8'h01);
		i_far.send(1'b0, 8'h02);
		rd_chk(LSTAT_ADDR, 32'h23);
		rd_chk(ALIAS_3, 32'h02);
		rd_chk(ISTAT_ADDR, 32'h3);
		chk_bit(irq, 1'b0);
		wr(IMASK_ADDR, 32'h2);
		chk_bit(irq, 1'b1);
		wr(ISTAT_ADDR, 32'h2);
		chk_bit(irq, 1'b0);
		rd_chk(ISTAT_ADDR, 32'h1);
		axi_wr(32'h50001190, 32'h1, r);
		chk_word({30'h0, r}, {30'h0, RESP_SLVERR});
		axi_rd(32'h50001190, d, r);
		chk_word({30'h0, r}, {30'h0, RESP_SLVERR});
		chk_word(d, 32'h0);
		wr(LSTAT_ADDR, 32'h0);
		rd_chk(LSTAT_ADDR, 32'h20);
		wr(CTRL_ADDR, 32'h2);
		i_far.send(1'b1, 8'h3c);
		rd_chk(SHADOW_LAST, 32'h3c);
		// Held transmitter: a second write replaces the first
		@(posedge mclk);
		stall <= 1'b1;
		wr(ALIAS_2, 32'h11);
		rd_chk(LSTAT_ADDR, 32'h0);
		wr(SHADOW_BASE, 32'hff22);
		drain_chk(1, 1'b1, 8'h22);
		wr(CTRL_ADDR, 32'h1);
		wr(ISTAT_ADDR, 32'h7);
		@(posedge mclk);
		stall <= 1'b1;
		for (int i = 0; i < 17; i++)
			wr(SHADOW_BASE + 32'(4 * (i % 16)), 32'(8'h60 + i));
		rd_chk(ISTAT_ADDR, 32'h4);
		drain_chk(16, 1'b0, 8'h60);
		wr(ISTAT_ADDR, 32'h7);
		for (int i = 0; i < 17; i++)
			i_far.send(1'b0, 8'h40 + 8'(i));
		rd_chk(LSTAT_ADDR, 32'h23);
		rd_chk(ISTAT_ADDR, 32'h3);
		for (int i = 0; i < 16; i++)
			rd_chk(SHADOW_BASE + 32'(4 * i), 32'(8'h40 + i));
		rd_chk(LSTAT_ADDR, 32'h20);
		report_and_stop();
	end
	// Whole run is about 310 cycles; a hang is cut off well past that
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		$display("mismatch %0t watchdog expired", $time);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
